//--- rtl/eepfe_pkg.sv
package eepfe_pkg;

   // ---------------------------------------------------------------
   // Array geometry
   // ---------------------------------------------------------------
   localparam int EEPFE_MEM_BYTES  = 8192;
   localparam int EEPFE_ADDR_W     = 13;
   localparam int EEPFE_PAGE_BYTES = 32;
   localparam int EEPFE_PAGE_W     = 5;

   // ---------------------------------------------------------------
   // Select byte and command fields
   // ---------------------------------------------------------------
   localparam int         EEPFE_RW_BIT        = 0;
   localparam int         EEPFE_A10_BIT       = 2;
   localparam int         EEPFE_LOCK_DATA_BIT = 1;
   localparam logic [2:0] EEPFE_STRAP_FIVE    = 3'h1;
   localparam logic [3:0] EEPFE_BIT_FIRST     = 4'h1;
   localparam logic [3:0] EEPFE_BIT_LAST      = 4'h7;
   localparam logic [3:0] EEPFE_BIT_ACK       = 4'h8;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int EEPFE_CLK_HZ         = 50_000_000;
   localparam int EEPFE_WRITE_CYCLE_US = 5000;
   localparam int EEPFE_WRITE_CYCLE_CYC =
      (EEPFE_CLK_HZ / 1_000_000) * EEPFE_WRITE_CYCLE_US;

   // ---------------------------------------------------------------
   // Protocol states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV  = 3'h1,
      ST_AHI  = 3'h2,
      ST_ALO  = 3'h3,
      ST_WDAT = 3'h4,
      ST_RDAT = 3'h5,
      ST_BUSY = 3'h6
   } eepfe_state_t;

endpackage

//--- rtl/eepfe_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
module eepfe_pin_filter (
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output logic      level_o
);

   typedef struct packed {
      logic [2:0] sync;
      logic       level;
   } eepfe_filt_t;

   eepfe_filt_t q;
   eepfe_filt_t n;

   // ---------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree
   // ---------------------------------------------------------------
   always_comb begin
      n      = q;
      n.sync = {q.sync[1:0], pin_i};
      if (q.sync[1] == q.sync[2]) begin
         n.level = q.sync[2];
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         q <= 4'hF;
      end else begin
         q <= n;
      end
   end

   assign level_o = q.level;

endmodule
`default_nettype wire

//--- rtl/eepfe_sda_drive.sv
`timescale 1ns/1ns
`default_nettype none
module eepfe_sda_drive (
   input  wire logic scl_i,
   input  wire logic reset_i,
   input  wire logic pull_low_i,
   output logic      sda_o,
   output logic      sda_oe_n_o
);

   typedef struct packed {
      logic oe_n;
      logic dat;
   } eepfe_drv_t;

   eepfe_drv_t q;
   eepfe_drv_t n;

   // ---------------------------------------------------------------
   // Data line changes only while the bus clock is low; the request
   // level is settled one clock high-phase before this edge
   // ---------------------------------------------------------------
   always_comb begin
      n      = q;
      n.dat  = 1'b0;
      n.oe_n = ~pull_low_i;
   end

   always_ff @(negedge scl_i or posedge reset_i) begin
      if (reset_i) begin
         q <= 2'h2;
      end else begin
         q <= n;
      end
   end

   assign sda_o      = q.dat;
   assign sda_oe_n_o = q.oe_n;

endmodule
`default_nettype wire

//--- rtl/eepfe_top.sv
`timescale 1ns/1ns
`default_nettype none
module eepfe_top
   import eepfe_pkg::*;
#(
   parameter int         WRITE_CYCLE_CYC = EEPFE_WRITE_CYCLE_CYC,
   parameter bit         FIVE_BALL       = 1'b0,
   parameter bit         ID_PAGE_EN      = 1'b1,
   parameter logic [3:0] MEM_TYPE        = 4'hA,
   parameter logic [3:0] ID_TYPE         = 4'h9  // Arbitrary value
) (
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [2:0] straps_i,
   input  wire logic [2:0] straps_conn_i,
   input  wire logic       write_inhibit_i,
   input  wire logic       write_inhibit_conn_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   output logic            busy_o,
   output logic            standby_o,
   output logic            id_locked_o
);

   localparam int TMR_W = $clog2(WRITE_CYCLE_CYC + 1);

   if (WRITE_CYCLE_CYC < 1) begin : g_bad_cycle
      $error("WRITE_CYCLE_CYC must be at least one");
   end

   typedef struct packed {
      eepfe_state_t            st;
      logic [3:0]              cnt;
      logic [7:0]              sh;
      logic [EEPFE_ADDR_W-1:0] addr;
      logic                    id_sel;
      logic                    a10;
      logic                    rd;
      logic                    drv;
      logic                    wr_pend;
      logic                    lock_req;
      logic [EEPFE_PAGE_BYTES-1:0] mask;
      logic [TMR_W-1:0]        tmr;
      logic                    locked;
      logic                    scl_l;
      logic                    sda_l;
      logic                    stby;
      logic                    busy;
   } eepfe_core_t;

   eepfe_core_t q;
   eepfe_core_t n;

   logic [7:0] mem_arr [EEPFE_MEM_BYTES];
   logic [7:0] id_arr  [EEPFE_PAGE_BYTES];
   logic [7:0] pbuf    [EEPFE_PAGE_BYTES];

   logic       scl_f;
   logic       sda_f;
   logic [2:0] straps_eff;
   logic       wi_eff;
   logic       rise;
   logic       start;
   logic       stop;
   logic       match;
   logic       wr_ok;
   logic       buf_we;
   logic       commit;
   logic [7:0] rd_byte;
   logic [7:0] nb;

   // ---------------------------------------------------------------
   // Pin conditioning
   // ---------------------------------------------------------------
   eepfe_pin_filter u_scl_filt (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .pin_i     (scl_i),
      .level_o   (scl_f)
   );

   eepfe_pin_filter u_sda_filt (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .pin_i     (sda_i),
      .level_o   (sda_f)
   );

   assign straps_eff = FIVE_BALL ? EEPFE_STRAP_FIVE
                     : (straps_i & straps_conn_i);
   assign wi_eff     = write_inhibit_i & write_inhibit_conn_i;

   assign rise  = scl_f & ~q.scl_l;
   assign start = scl_f & q.scl_l & q.sda_l & ~sda_f;
   assign stop  = scl_f & q.scl_l & ~q.sda_l & sda_f;
   assign nb    = {q.sh[6:0], sda_f};

   assign match = (nb[7:4] == MEM_TYPE
                  || (ID_PAGE_EN && nb[7:4] == ID_TYPE))
                  && nb[3:1] == straps_eff;

   assign rd_byte = q.id_sel ? id_arr[q.addr[EEPFE_PAGE_W-1:0]]
                  : mem_arr[q.addr];

   always_comb begin
      if (wi_eff) begin
         wr_ok = 1'b0;
      end else if (!q.id_sel) begin
         wr_ok = 1'b1;
      end else if (q.a10) begin
         wr_ok = !q.locked && nb[EEPFE_LOCK_DATA_BIT];
      end else begin
         wr_ok = !q.locked;
      end
   end

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   always_comb begin
      n       = q;
      buf_we  = 1'b0;
      commit  = 1'b0;
      n.scl_l = scl_f;
      n.sda_l = sda_f;
      case (q.st)
         ST_BUSY: begin
            n.drv = 1'b0;
            if (q.tmr == TMR_W'(1)) begin
               n.st  = ST_IDLE;
               n.tmr = '0;
            end else begin
               n.tmr = q.tmr - TMR_W'(1);
            end
         end
         default: begin
            if (start) begin
               n.st       = ST_DEV;
               n.cnt      = '0;
               n.drv      = 1'b0;
               n.wr_pend  = 1'b0;
               n.lock_req = 1'b0;
               n.mask     = '0;
            end else if (stop) begin
               n.drv     = 1'b0;
               n.wr_pend = 1'b0;
               n.st      = ST_IDLE;
               if (q.st == ST_WDAT && q.wr_pend && q.cnt == EEPFE_BIT_FIRST) begin
                  n.st   = ST_BUSY;
                  n.tmr  = TMR_W'(WRITE_CYCLE_CYC);
                  commit = 1'b1;
                  if (q.lock_req) begin
                     n.locked = 1'b1;
                  end
               end
            end else if (rise && q.st != ST_IDLE) begin
               if (q.cnt != EEPFE_BIT_ACK) begin
                  n.cnt = q.cnt + 4'h1;
                  if (q.st == ST_RDAT) begin
                     n.sh  = {q.sh[6:0], 1'b0};
                     n.drv = (q.cnt == EEPFE_BIT_LAST) ? 1'b0 : ~q.sh[6];
                  end else begin
                     n.sh = nb;
                  end
                  if (q.cnt == EEPFE_BIT_LAST) begin
                     case (q.st)
                        ST_DEV: begin
                           n.drv    = match;
                           n.id_sel = ID_PAGE_EN && nb[7:4] == ID_TYPE;
                           n.rd     = nb[EEPFE_RW_BIT];
                           if (!match) begin
                              n.st = ST_IDLE;
                           end
                        end
                        ST_AHI: begin
                           n.drv = 1'b1;
                           n.a10 = nb[EEPFE_A10_BIT];
                           n.addr[EEPFE_ADDR_W-1:8] = nb[EEPFE_ADDR_W-9:0];
                        end
                        ST_ALO: begin
                           n.drv       = 1'b1;
                           n.addr[7:0] = nb;
                        end
                        ST_WDAT: begin
                           n.drv     = wr_ok;
                           n.wr_pend = wr_ok;
                           if (wr_ok && q.id_sel && q.a10) begin
                              n.lock_req = 1'b1;
                           end else if (wr_ok) begin
                              buf_we = 1'b1;
                              n.mask[q.addr[EEPFE_PAGE_W-1:0]] = 1'b1;
                              n.addr[EEPFE_PAGE_W-1:0] = q.addr[EEPFE_PAGE_W-1:0] + 5'h1;
                           end
                        end
                        default: begin
                           n.drv = 1'b0;
                        end
                     endcase
                  end
               end else begin
                  n.cnt = '0;
                  case (q.st)
                     ST_DEV: begin
                        if (q.rd) begin
                           n.st   = ST_RDAT;
                           n.sh   = rd_byte;
                           n.drv  = ~rd_byte[7];
                           n.addr = q.addr + 13'h1;
                        end else begin
                           n.st  = ST_AHI;
                           n.drv = 1'b0;
                        end
                     end
                     ST_AHI: begin
                        n.st  = ST_ALO;
                        n.drv = 1'b0;
                     end
                     ST_ALO: begin
                        n.st  = ST_WDAT;
                        n.drv = 1'b0;
                     end
                     ST_RDAT: begin
                        if (sda_f) begin
                           n.st  = ST_IDLE;
                           n.drv = 1'b0;
                        end else begin
                           n.sh   = rd_byte;
                           n.drv  = ~rd_byte[7];
                           n.addr = q.addr + 13'h1;
                        end
                     end
                     default: begin
                        n.drv = 1'b0;
                     end
                  endcase
               end
            end
         end
      endcase
      n.stby = n.st == ST_IDLE;
      n.busy = n.st == ST_BUSY;
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         q      <= '0;
         q.stby <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------------------------
   // Page buffer and array commit
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (buf_we) begin
         pbuf[q.addr[EEPFE_PAGE_W-1:0]] <= nb;
      end
      if (commit) begin
         for (int i = 0; i < EEPFE_PAGE_BYTES; i++) begin
            if (q.mask[i] && q.id_sel) begin
               id_arr[i] <= pbuf[i];
            end else if (q.mask[i]) begin
               mem_arr[{q.addr[EEPFE_ADDR_W-1:EEPFE_PAGE_W],
                        EEPFE_PAGE_W'(i)}] <= pbuf[i];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Line driver in the bus clock domain
   // ---------------------------------------------------------------
   eepfe_sda_drive u_drive (
      .scl_i      (scl_i),
      .reset_i    (reset_i),
      .pull_low_i (q.drv),
      .sda_o      (sda_o),
      .sda_oe_n_o (sda_oe_n_o)
   );

   assign busy_o      = q.busy;
   assign standby_o   = q.stby;
   assign id_locked_o = q.locked;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   sequence s_sel_done;
      q.st == ST_DEV && rise && q.cnt == EEPFE_BIT_LAST;
   endsequence

   sequence s_data_done;
      q.st == ST_WDAT && rise && q.cnt == EEPFE_BIT_LAST;
   endsequence

   a_sel_match: assert property (s_sel_done and match |=> q.drv)
      else $error("Matching select byte not acknowledged");
   a_sel_miss: assert property (s_sel_done and !match |=> !q.drv && q.st == ST_IDLE)
      else $error("Mismatched select byte not released");
   a_five_ball: assert property (FIVE_BALL |-> straps_eff == 3'h1)
      else $error("Five-ball strap pattern wrong");
   a_float_zero: assert property (!FIVE_BALL && straps_conn_i == 3'h0 |-> straps_eff == 3'h0)
      else $error("Unconnected straps not read as zero");
   a_inhibit_nack: assert property (s_data_done and wi_eff
      |=> !q.drv && !q.wr_pend && q.mask == $past(q.mask))
      else $error("Inhibited data byte acknowledged or stored");
   a_addr_ack: assert property ((q.st == ST_AHI || q.st == ST_ALO) && rise
      && q.cnt == EEPFE_BIT_LAST |=> q.drv)
      else $error("Address byte not acknowledged");
   a_idle_hold: assert property (q.st == ST_IDLE && !start |=> q.st == ST_IDLE && !q.drv)
      else $error("Left standby without start");
   a_por_idle: assert property (disable iff (1'b0) $fell(reset_i) |-> q.st == ST_IDLE && q.stby)
      else $error("Not in standby after reset release");
   a_write_go: assert property (stop && q.st == ST_WDAT && q.wr_pend
      && q.cnt == EEPFE_BIT_FIRST |=> q.st == ST_BUSY && q.busy)
      else $error("Write cycle not started");
   a_write_only: assert property (q.st != ST_BUSY
      && !(stop && q.st == ST_WDAT && q.wr_pend && q.cnt == EEPFE_BIT_FIRST) |=> q.st != ST_BUSY)
      else $error("Write cycle started in wrong slot");
   a_busy_quiet: assert property (q.st == ST_BUSY && q.tmr != TMR_W'(1)
      |=> q.st == ST_BUSY && !q.drv && q.tmr == $past(q.tmr) - TMR_W'(1))
      else $error("Bus activity during write cycle");
   a_read_dir: assert property (q.st == ST_DEV && rise && q.cnt == EEPFE_BIT_ACK
      |=> q.st == (q.rd ? ST_RDAT : ST_AHI))
      else $error("Direction bit ignored");
   a_lock_stays: assert property ($past(q.locked) |-> q.locked)
      else $error("Identification page unlocked");
   a_drive_rise: assert property ($changed(q.drv) |-> $past(rise || start || stop || q.st == ST_BUSY))
      else $error("Drive request moved off a clock edge");
   a_open_drain: assert property (!sda_o)
      else $error("Data line driven high");

endmodule
`default_nettype wire

//--- verif/eepfe_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
module eepfe_bus_master (
   input  wire logic link_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_n_o
);
   // Bus idles with the clock standing high and data released
   initial begin
      scl_o      = 1'b1;
      sda_oe_n_o = 1'b1;
   end

   // -------------------------------------------------------------
   // Bit level
   // -------------------------------------------------------------
   // One quarter bit is eight link clocks, well above the filter delay
   task automatic q(input int n);
      repeat (n * 8) @(posedge link_clk_i);
   endtask

   task automatic start_c();
      @(posedge link_clk_i);
      sda_oe_n_o <= 1'b1;
      q(1);
      scl_o <= 1'b1;
      q(2);
      sda_oe_n_o <= 1'b0;
      q(2);
      scl_o <= 1'b0;
   endtask

   // Always ends a frame with a stop, which returns the slave to standby unless it starts a write cycle or one is still running
   task automatic stop_c();
      @(posedge link_clk_i);
      sda_oe_n_o <= 1'b0;
      q(1);
      scl_o <= 1'b1;
      q(2);
      sda_oe_n_o <= 1'b1;
      q(2);
   endtask

   task automatic bit_x(input logic b, output logic r);
      sda_oe_n_o <= b;
      q(1);
      scl_o <= 1'b1;
      q(2);
      r = sda_i;
      scl_o <= 1'b0;
      q(1);
   endtask

   // -------------------------------------------------------------
   // Byte level
   // -------------------------------------------------------------
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic byte_r(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(nack, r);
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
   localparam int         WCYC = 400;
   localparam logic [3:0] MT   = 4'hA;
   localparam logic [3:0] IT   = 4'h9;  // Arbitrary value

   logic       clk_sys, reset, link_clk, scl, m_oe_n, sda;
   logic [2:0] straps, straps_conn;
   logic       wi, wi_conn, d_sda, d_oe_n, busy, standby, locked;
   logic [2:0] cs;
   int         bad_count;
   int         n_compared;

   // Wired-AND with pull-up
   assign sda = m_oe_n & (d_oe_n | d_sda);

   eepfe_top #(.WRITE_CYCLE_CYC(WCYC), .MEM_TYPE(MT), .ID_TYPE(IT)) dut (
      .clk_sys_i(clk_sys), .reset_i(reset), .scl_i(scl), .sda_i(sda),
      .straps_i(straps), .straps_conn_i(straps_conn), .write_inhibit_i(wi),
      .write_inhibit_conn_i(wi_conn), .sda_o(d_sda), .sda_oe_n_o(d_oe_n),
      .busy_o(busy), .standby_o(standby), .id_locked_o(locked));

   eepfe_bus_master mst (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      link_clk = 1'b0;
      #3;
      forever begin
         #7 link_clk = 1'b1;
         #8 link_clk = 1'b0;
      end
   end

   always @(posedge clk_sys) begin
      if (d_oe_n === 1'b0) `CHECK("sda_o", 1'b0, d_sda)
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic xfer(input logic [7:0] b, input logic ex);
      logic a;
      mst.byte_w(b, a);
      `CHECK("ack", ex, a)
   endtask

   task automatic wr(input logic [3:0] tp, input logic [12:0] a, input logic [7:0] d, input logic [3:0] e);
      mst.start_c();
      xfer({tp, cs, 1'b0}, e[3]);
      xfer({3'h0, a[12:8]}, e[2]);
      xfer(a[7:0], e[1]);
      xfer(d, e[0]);
      mst.stop_c();
   endtask

   task automatic rd(input logic [3:0] tp, input logic [12:0] a, input logic [7:0] ex);
      logic [7:0] d;
      mst.start_c();
      xfer({tp, cs, 1'b0}, 1'b1);
      xfer({3'h0, a[12:8]}, 1'b1);
      xfer(a[7:0], 1'b1);
      mst.start_c();
      xfer({tp, cs, 1'b1}, 1'b1);
      mst.byte_r(1'b1, d);
      mst.stop_c();
      `CHECK("read data", ex, d)
   endtask

   task automatic wait_idle();
      for (int i = 0; i < WCYC + 100 && busy !== 1'b0; i++) @(posedge clk_sys);
      `CHECK("busy", 1'b0, busy)
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      `CHECK("standby", 1'b1, standby)
      `CHECK("busy", 1'b0, busy)
      `CHECK("oe_n", 1'b1, d_oe_n)
      `CHECK("locked", 1'b0, locked)
   endtask

   task automatic t_select();
      mst.start_c();
      xfer({MT, 3'h2, 1'b0}, 1'b0);
      mst.stop_c();
      `CHECK("standby", 1'b1, standby)
      mst.start_c();
      xfer({MT, 3'h5, 1'b0}, 1'b1);
      mst.stop_c();
      @(posedge clk_sys);
      straps_conn <= 3'h3;
      mst.start_c();
      xfer({MT, 3'h5, 1'b0}, 1'b0);
      mst.start_c();
      xfer({MT, 3'h1, 1'b0}, 1'b1);
      mst.stop_c();
      @(posedge clk_sys);
      straps_conn <= 3'h7;
   endtask

   task automatic t_write();
      logic [7:0] d0;
      logic [7:0] d1;
      wr(MT, 13'h1FFF, 8'h5A, 4'hF);
      `CHECK("busy", 1'b1, busy)
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b0);
      mst.stop_c();
      wait_idle();
      rd(MT, 13'h1FFF, 8'h5A);
      wr(MT, 13'h0000, 8'hA5, 4'hF);
      wait_idle();
      rd(MT, 13'h0000, 8'hA5);
      // Sequential read across the top of the array wraps to zero
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b1);
      xfer(8'h1F, 1'b1);
      xfer(8'hFF, 1'b1);
      mst.start_c();
      xfer({MT, cs, 1'b1}, 1'b1);
      mst.byte_r(1'b0, d0);
      mst.byte_r(1'b1, d1);
      mst.stop_c();
      `CHECK("seq read 0", 8'h5A, d0)
      `CHECK("seq read 1", 8'hA5, d1)
   endtask

   task automatic t_inhibit();
      @(posedge clk_sys);
      wi_conn <= 1'b1;
      wr(MT, 13'h1FFF, 8'hC3, 4'hE);
      `CHECK("busy", 1'b0, busy)
      rd(MT, 13'h1FFF, 8'h5A);
      @(posedge clk_sys);
      wi <= 1'b0;
   endtask

   task automatic t_early_stop();
      logic r;
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h10, 1'b1);
      mst.stop_c();
      `CHECK("busy", 1'b0, busy)
      `CHECK("standby", 1'b1, standby)
      // Stop in the middle of the byte after an acknowledged data byte
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b1);
      xfer(8'h00, 1'b1);
      xfer(8'h20, 1'b1);
      xfer(8'h3C, 1'b1);
      mst.bit_x(1'b0, r);
      mst.bit_x(1'b0, r);
      mst.stop_c();
      `CHECK("busy", 1'b0, busy)
      `CHECK("standby", 1'b1, standby)
   endtask

   task automatic t_id();
      wr(IT, 13'h0003, 8'h77, 4'hF);
      wait_idle();
      rd(IT, 13'h0003, 8'h77);
      wr(IT, 13'h0400, 8'h02, 4'hF);
      wait_idle();
      `CHECK("locked", 1'b1, locked)
      wr(IT, 13'h0003, 8'h11, 4'hE);
      `CHECK("busy", 1'b0, busy)
      rd(IT, 13'h0003, 8'h77);
   endtask

   task automatic t_power();
      @(posedge clk_sys);
      reset <= 1'b1;
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b0);
      mst.stop_c();
      `CHECK("standby", 1'b1, standby)
      `CHECK("locked", 1'b0, locked)
      @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      mst.start_c();
      xfer({MT, cs, 1'b0}, 1'b1);
      mst.stop_c();
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      bad_count++;
      complete_run();
   end

   initial begin
      bad_count   = 0;
      n_compared  = 0;
      reset       = 1'b1;
      straps      = 3'h5;
      straps_conn = 3'h7;
      cs          = 3'h5;
      wi          = 1'b1;
      wi_conn     = 1'b0;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_select();
      t_write();
      t_inhibit();
      t_early_stop();
      t_id();
      t_power();
      complete_run();
   end
endmodule
`default_nettype wire
